// [sws_defines.svh]
// Purpose: constants of the subtract datapath: opcodes, register map, flag positions
// Assumes: included by bare name wherever a constant is needed
// Notes: byte offsets are word aligned on a 32-bit bus
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH

// opcode fields of the two subtract instructions
`define SWS_OP_LIT_HI 8'h08
`define SWS_OP_REG_HI 6'h17

// instruction word field positions
`define SWS_DEST_BIT 9
`define SWS_BANKSEL_BIT 8

// register byte offsets
`define SWS_OFF_INSTR 8'h00
`define SWS_OFF_ACC 8'h04
`define SWS_OFF_STATUS 8'h08
`define SWS_OFF_BANK 8'h0c
`define SWS_OFF_MADDR 8'h10
`define SWS_OFF_MDATA 8'h14
`define SWS_OFF_EXEC 8'h18

// status flag positions
`define SWS_ST_C 0
`define SWS_ST_DC 1
`define SWS_ST_Z 2
`define SWS_ST_OV 3
`define SWS_ST_N 4

// execution status positions
`define SWS_EX_BUSY 0
`define SWS_EX_ILLEGAL 1

// reset values
`define SWS_RST_INSTR 16'h0000
`define SWS_RST_ACC 8'h00
`define SWS_RST_STATUS 8'h00

// lower half of the shared access bank maps to bank zero, upper to the top bank
`define SWS_ACCESS_SPLIT 8'h80

`endif

// [sws_pkg.sv]
// Purpose: shared types of the subtract datapath
// Assumes: nothing
// Notes: carriers between decoder, arithmetic unit and top
package sws_pkg;

    // sequencer phases, Q1 to Q4 one core clock each
    typedef enum logic [2:0] {
        SWS_IDLE,
        SWS_Q1,
        SWS_Q2,
        SWS_Q3,
        SWS_Q4
    } sws_phase_t;

    // decoded instruction
    typedef struct packed {
        logic valid;
        logic is_lit;
        logic dest_f;
        logic use_bank;
        logic [7:0] k;
    } sws_dec_t;

    // arithmetic flags
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } sws_flags_t;

    // arithmetic result
    typedef struct packed {
        logic [7:0] diff;
        sws_flags_t flags;
    } sws_alu_t;

endpackage

// [sws_decode.sv]
// Purpose: decode of the two subtract instruction words
// Assumes: word is stable while it is decoded
// Notes: purely combinational
`include "sws_defines.svh"

module sws_decode (
    // instruction in
    input wire logic [15:0] i_word,
    // decoded out
    output sws_pkg::sws_dec_t o_dec
);

    logic lit_hit;
    logic reg_hit;

    // opcode match
    assign lit_hit = (i_word[15:8] == `SWS_OP_LIT_HI); // RL1
    assign reg_hit = (i_word[15:10] == `SWS_OP_REG_HI); // RL8

    // field split
    always_comb begin
        o_dec.valid = lit_hit | reg_hit;
        o_dec.is_lit = lit_hit;
        o_dec.dest_f = reg_hit & i_word[`SWS_DEST_BIT]; // RL10 RL11
        o_dec.use_bank = reg_hit & i_word[`SWS_BANKSEL_BIT]; // RL12 RL13
        o_dec.k = i_word[7:0];
    end

endmodule

// [sws_alu.sv]
// Purpose: eight-bit subtract with flag generation
// Assumes: minuend is the literal or register, subtrahend the accumulator
// Notes: carry and digit carry are set when no borrow occurs
module sws_alu (
    // operands
    input wire logic [7:0] i_minuend,
    input wire logic [7:0] i_subtrahend,
    // result
    output sws_pkg::sws_alu_t o_res
);

    logic [8:0] full;
    logic [4:0] low;

    // wide differences expose the borrows
    assign full = {1'b0, i_minuend} - {1'b0, i_subtrahend}; // RL2 RL9
    assign low = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]};

    // result and flags
    always_comb begin
        o_res.diff = full[7:0]; // RL5
        o_res.flags.n = full[7]; // RL5 RL6 RL7
        o_res.flags.z = (full[7:0] == 8'h00); // RL5 RL6 RL7
        o_res.flags.c = ~full[8]; // RL5 RL6 RL7
        o_res.flags.dc = ~low[4]; // RL15
        o_res.flags.ov = (i_minuend[7] ^ i_subtrahend[7]) & (i_minuend[7] ^ full[7]); // RL15
    end

endmodule

// [sws_top.sv]
// Purpose: subtract datapath of a small core, run from an APB register file
// Assumes: APB master follows the usual setup then access order; inputs synchronous
// Notes: one instruction takes five core clocks: start plus four phases
//
// How it works
// RL1 - A word whose upper byte is 0000 1000 is the literal subtract, low byte the literal.
// RL2 - The literal subtract computes the literal minus the accumulator into the accumulator.
// RL3 - The literal subtract is one word and one cycle of decode, read, process, write.
// RL4 - Both subtracts update N, OV, C, DC and Z and leave other status bits alone.
// RL5 - A negative result is kept as two's complement with N set and C and Z cleared.
// RL6 - A zero result sets Z and C and clears N.
// RL7 - A positive nonzero result sets C and clears Z and N.
// RL8 - A word whose top six bits are 010111 is the register subtract with d, a and address.
// RL9 - The register subtract computes the addressed register minus the accumulator.
// RL10 - With d clear the difference goes to the accumulator and the register is kept.
// RL11 - With d set the difference goes back to the addressed register.
// RL12 - With a clear the address is resolved in the shared access bank.
// RL13 - With a set the address is resolved in the bank chosen by the bank selector.
// RL14 - The register subtract is one word and one cycle of decode, read, process, write.
// RL15 - OV shows signed overflow and DC shows no borrow out of the low nibble.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "sws_defines.svh"

module sws_top #(
    parameter int BANK_W = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // core status
    output logic o_busy
);

    localparam int MEM_AW = BANK_W + 8;
    localparam int MEM_DEPTH = 1 << MEM_AW;

    // refuse widths the memory cannot serve, at elaboration
    if (BANK_W < 1 || BANK_W > 8) begin : g_bank_w_check
        $error("sws_top: BANK_W must lie between 1 and 8");
    end

    // all state of the block apart from the data memory and busy_q
    typedef struct packed {
        sws_pkg::sws_phase_t phase;
        logic [15:0] instr;
        sws_pkg::sws_dec_t dec;
        logic [7:0] operand;
        sws_pkg::sws_alu_t res;
        logic [MEM_AW-1:0] eff;
        logic [7:0] acc;
        logic [7:0] status;
        logic [BANK_W-1:0] bank;
        logic [MEM_AW-1:0] maddr;
        logic illegal;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sws_state_t;

    sws_state_t q;
    sws_state_t d;

    // data memory, banked
    logic [7:0] mem [MEM_DEPTH];
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    // decoded word and arithmetic result
    sws_pkg::sws_dec_t dec_w;
    sws_pkg::sws_alu_t alu_w;

    sws_decode u_decode (
        .i_word(q.instr),
        .o_dec(dec_w)
    );

    sws_alu u_alu (
        .i_minuend(q.operand),
        .i_subtrahend(q.acc),
        .o_res(alu_w)
    );

    // bus phase decode
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd;
    logic [MEM_AW-1:0] eff_w;
    logic idle;

    assign idle = (q.phase == sws_pkg::SWS_IDLE);
    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable & q.pready;

    // effective data address from the bank bit
    always_comb begin
        if (q.dec.use_bank) begin
            eff_w = {q.bank, q.dec.k}; // RL13
        end else if (q.dec.k < `SWS_ACCESS_SPLIT) begin
            eff_w = {{BANK_W{1'b0}}, q.dec.k}; // RL12
        end else begin
            eff_w = {{BANK_W{1'b1}}, q.dec.k}; // RL12
        end
    end

    // read mux for the setup cycle
    always_comb begin
        mapped = 1'b1;
        rd = 32'h0000_0000;
        case (i_paddr)
            `SWS_OFF_INSTR: rd[15:0] = q.instr;
            `SWS_OFF_ACC: rd[7:0] = q.acc;
            `SWS_OFF_STATUS: rd[7:0] = q.status;
            `SWS_OFF_BANK: rd[BANK_W-1:0] = q.bank;
            `SWS_OFF_MADDR: rd[MEM_AW-1:0] = q.maddr;
            `SWS_OFF_MDATA: rd[7:0] = mem[q.maddr];
            `SWS_OFF_EXEC: begin
                rd[`SWS_EX_BUSY] = ~idle;
                rd[`SWS_EX_ILLEGAL] = q.illegal;
            end
            default: mapped = 1'b0;
        endcase
    end

    // next state: bus side first, then the sequencer, which wins on conflict
    always_comb begin
        d = q;
        mem_we = 1'b0;
        mem_wa = q.maddr;
        mem_wd = i_pwdata[7:0];

        // zero wait answer, registered
        d.pready = setup;
        d.pslverr = setup & ~mapped;
        if (setup) begin
            d.prdata = rd;
        end

        // register writes at the access edge
        if (access && i_pwrite) begin
            case (i_paddr)
                `SWS_OFF_INSTR: begin
                    if (idle) begin
                        d.instr = i_pwdata[15:0];
                        d.phase = sws_pkg::SWS_Q1;
                        d.illegal = 1'b0;
                    end
                end
                `SWS_OFF_ACC: d.acc = i_pwdata[7:0];
                `SWS_OFF_STATUS: d.status = i_pwdata[7:0];
                `SWS_OFF_BANK: d.bank = i_pwdata[BANK_W-1:0];
                `SWS_OFF_MADDR: d.maddr = i_pwdata[MEM_AW-1:0];
                `SWS_OFF_MDATA: mem_we = 1'b1;
                default: ;
            endcase
        end

        // four phase instruction cycle
        case (q.phase)
            sws_pkg::SWS_IDLE: ;
            sws_pkg::SWS_Q1: begin
                // decode
                d.dec = dec_w; // RL1 RL8
                if (dec_w.valid) begin
                    d.phase = sws_pkg::SWS_Q2; // RL3 RL14
                end else begin
                    d.illegal = 1'b1;
                    d.phase = sws_pkg::SWS_IDLE;
                end
            end
            sws_pkg::SWS_Q2: begin
                // read literal or register
                d.eff = eff_w;
                if (q.dec.is_lit) begin
                    d.operand = q.dec.k; // RL2
                end else begin
                    d.operand = mem[eff_w]; // RL9
                end
                d.phase = sws_pkg::SWS_Q3; // RL3 RL14
            end
            sws_pkg::SWS_Q3: begin
                // process data
                d.res = alu_w;
                d.phase = sws_pkg::SWS_Q4; // RL3 RL14
            end
            sws_pkg::SWS_Q4: begin
                // write destination
                if (q.dec.dest_f) begin
                    mem_we = 1'b1; // RL11
                    mem_wa = q.eff;
                    mem_wd = q.res.diff;
                end else begin
                    d.acc = q.res.diff; // RL2 RL10
                end
                d.status[`SWS_ST_N] = q.res.flags.n; // RL4
                d.status[`SWS_ST_OV] = q.res.flags.ov; // RL4
                d.status[`SWS_ST_Z] = q.res.flags.z; // RL4
                d.status[`SWS_ST_DC] = q.res.flags.dc; // RL4
                d.status[`SWS_ST_C] = q.res.flags.c; // RL4
                d.phase = sws_pkg::SWS_IDLE;
            end
            default: d.phase = sws_pkg::SWS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.phase <= sws_pkg::SWS_IDLE;
            q.instr <= `SWS_RST_INSTR;
            q.acc <= `SWS_RST_ACC;
            q.status <= `SWS_RST_STATUS;
        end else begin
            q <= d;
        end
    end

    // memory write port, no reset
    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // outputs from flip-flops
    assign o_prdata = q.prdata;
    assign o_pready = q.pready;
    assign o_pslverr = q.pslverr;

    // busy mirrors the phase register
    logic busy_q;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (d.phase != sws_pkg::SWS_IDLE);
        end
    end
    assign o_busy = busy_q;

endmodule

// [sws_top_monitor.sv]
// Purpose: bus and sequencing checks of the subtract datapath
// Assumes: bound to sws_top, sees its ports only
// Notes: one clock domain, reset disables every check
module sws_top_monitor #(
    parameter int BANK_W = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // apb and status
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_busy
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // bus answer timing and content
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_ready_has_setup: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    a_err_zero_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error outside a zero answer");
    a_upper_read_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_err_unmapped: assert property (o_pready |->
        o_pslverr == (i_paddr > 8'h18 || i_paddr[1:0] != 2'b00))
        else $error("error flag does not match address");
    // execution sequencing
    a_busy_four_cycles: assert property ($rose(o_busy) ##1 o_busy |-> o_busy [*3] ##1 !o_busy)
        else $error("busy length wrong");
    a_instr_starts: assert property (i_psel && i_penable && o_pready && i_pwrite
        && i_paddr == 8'h00 && !o_busy |-> ##1 o_busy)
        else $error("instruction write did not start");
endmodule

bind sws_top sws_top_monitor #(.BANK_W(BANK_W)) u_mon (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy)
);

// [tb.sv]
// Purpose: self-checking bench of the subtract datapath over apb
// Assumes: zero wait state slave, five clocks per instruction
// Notes: read notes are queued by the driver and checked by a watcher
`include "sws_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic o_busy;
    logic [32:0] notes[$];
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;

    sws_top #(.BANK_W(4)) dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy)
    );

    // 100 mhz clock
    always #5 i_core_clk = ~i_core_clk;

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // watcher: each read answer against the oldest note
    always @(posedge i_core_clk) begin
        if (o_pready === 1'b1 && i_pwrite === 1'b0 && notes.size() > 0) begin
            cmp({o_pslverr, o_prdata}, notes.pop_front());
        end
    end

    // cuts a hang short
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // issue a word and let the four phases finish
    task automatic ex(input logic [15:0] w);
        apb(1'b1, `SWS_OFF_INSTR, {16'h0, w});
        repeat (6) @(posedge i_core_clk);
    endtask

    // minuend minus subtrahend: {diff, n, ov, z, dc, c}
    function automatic logic [12:0] sub(input logic [7:0] m, input logic [7:0] s);
        logic [8:0] r;
        r = {1'b0, m} - {1'b0, s};
        return {r[7:0], r[7], m[7] != s[7] && r[7] != m[7], r[7:0] == 8'h00,
            m[3:0] >= s[3:0], ~r[8]};
    endfunction

    initial begin
        logic [7:0] acc, m, f;
        logic [3:0] bk;
        logic [11:0] ad;
        logic [12:0] r;
        void'($urandom(20));
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // reset values and an unmapped place
        rd(`SWS_OFF_INSTR, 33'h0);
        rd(`SWS_OFF_ACC, 33'h0);
        rd(`SWS_OFF_STATUS, 33'h0);
        rd(`SWS_OFF_BANK, 33'h0);
        rd(`SWS_OFF_EXEC, 33'h0);
        rd(8'h1c, {1'b1, 32'h0});
        $display("test reset done");
        // literal subtract: positive, zero, negative, overflow, then random
        for (int i = 0; i < 8; i++) begin
            acc = (i < 3) ? 8'(i + 1) : (i == 3) ? 8'h01 : 8'($urandom);
            m = (i < 3) ? 8'h02 : (i == 3) ? 8'h80 : 8'($urandom);
            r = sub(m, acc);
            apb(1'b1, `SWS_OFF_ACC, {24'h0, acc});
            apb(1'b1, `SWS_OFF_STATUS, {24'h0, 3'h7, ~r[4:0]});
            ex({`SWS_OP_LIT_HI, m});
            rd(`SWS_OFF_ACC, {25'h0, r[12:5]});
            rd(`SWS_OFF_STATUS, {25'h0, 3'h7, r[4:0]});
        end
        $display("test literal done");
        // register subtract over every destination and bank choice
        for (int i = 0; i < 12; i++) begin
            bk = 4'($urandom_range(14, 1));
            f = 8'($urandom);
            acc = 8'($urandom);
            m = (i < 4) ? acc : 8'($urandom);
            ad = i[1] ? {bk, f} : {f[7] ? 4'hf : 4'h0, f};
            r = sub(m, acc);
            apb(1'b1, `SWS_OFF_BANK, {28'h0, bk});
            apb(1'b1, `SWS_OFF_MADDR, {20'h0, ad});
            apb(1'b1, `SWS_OFF_MDATA, {24'h0, m});
            apb(1'b1, `SWS_OFF_ACC, {24'h0, acc});
            apb(1'b1, `SWS_OFF_STATUS, {24'h0, 3'h7, ~r[4:0]});
            ex({`SWS_OP_REG_HI, i[0], i[1], f});
            rd(`SWS_OFF_ACC, {25'h0, i[0] ? acc : r[12:5]});
            rd(`SWS_OFF_MDATA, {25'h0, i[0] ? r[12:5] : m});
            rd(`SWS_OFF_STATUS, {25'h0, 3'h7, r[4:0]});
        end
        $display("test register done");
        // busy refusal, illegal word, busy flag, then a reset in mid-run
        r = sub(8'h09, 8'h05);
        apb(1'b1, `SWS_OFF_ACC, 32'h0000_0005);
        apb(1'b1, `SWS_OFF_STATUS, 32'h0000_0000);
        apb(1'b1, `SWS_OFF_INSTR, {16'h0, `SWS_OP_LIT_HI, 8'h09});
        apb(1'b1, `SWS_OFF_INSTR, 32'h0000_ffff); // lands in phase three, refused
        repeat (6) @(posedge i_core_clk);
        rd(`SWS_OFF_INSTR, {17'h0, `SWS_OP_LIT_HI, 8'h09});
        rd(`SWS_OFF_ACC, {25'h0, r[12:5]});
        ex(16'hffff);
        rd(`SWS_OFF_EXEC, 33'h2);
        rd(`SWS_OFF_ACC, {25'h0, r[12:5]});
        rd(`SWS_OFF_STATUS, {28'h0, r[4:0]});
        apb(1'b1, `SWS_OFF_INSTR, {16'h0, `SWS_OP_LIT_HI, r[12:5]});
        rd(`SWS_OFF_EXEC, 33'h1);
        repeat (6) @(posedge i_core_clk);
        rd(`SWS_OFF_ACC, 33'h0);
        apb(1'b1, `SWS_OFF_INSTR, {16'h0, `SWS_OP_LIT_HI, 8'h01});
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(`SWS_OFF_INSTR, 33'h0);
        rd(`SWS_OFF_ACC, 33'h0);
        rd(`SWS_OFF_STATUS, 33'h0);
        rd(`SWS_OFF_EXEC, 33'h0);
        $display("test control done");
        report_and_stop();
    end
endmodule
